// >>> debug_if_pkg.sv
// Purpose: constants and carrier types of the core debug signal interface
// Assumes: 32-bit AHB-Lite register slave, 100 MHz core clock
// Notes: register offsets are byte addresses
// Contract
// - comms_rx_full is high while the receive word has not been read by the core.
// - comms_tx_empty is high while the transmit word holds no data.
// - debug_state_ack is high exactly while the processor is in debug state; the block registers it, so it follows the debug state one cycle late.
// - a low debug_feature_enable disables every debug feature except the watch unit match outputs; the host lowers it only when no debug is needed.
//   the block leaves the comms flags, their interrupt events and instr_executed_flag ungated by it.
// - internal_halt_request goes to the core and is formed from external_halt_request and control bit 1.
// - a halt request enters debug state only once the current instruction has completed.
// - each watch condition input qualifies the match of its own watchpoint unit.
// - external_data_watch lets outside logic flag a data access as a watchpoint hit.
// - external_instr_break lets outside logic mark a fetched instruction as a breakpoint.
// - instr_executed_flag is high only when the previous cycle's execute instruction passed and ran.
// - each watch unit match output is high when its programmed conditions match the buses.
// - a watch unit match output is produced whatever that unit's enable bit says.
// - a high tracking-mode input puts the block into tracking debug mode, chosen by the host.
package debug_if_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_RX_DATA = 8'h08;
    localparam logic [7:0] OFF_TX_DATA = 8'h0c;
    localparam logic [7:0] OFF_COMMS = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
    localparam logic [7:0] OFF_IRQ_EN = 8'h1c;
    localparam logic [7:0] OFF_UNIT_BASE = 8'h40;
    localparam logic [7:0] UNIT_STRIDE = 8'h20;
    localparam logic [7:0] OFF_U_AVAL = 8'h00;
    localparam logic [7:0] OFF_U_AMASK = 8'h04;
    localparam logic [7:0] OFF_U_DVAL = 8'h08;
    localparam logic [7:0] OFF_U_DMASK = 8'h0c;
    localparam logic [7:0] OFF_U_CTRL = 8'h10;

    // control register fields
    localparam int CTRL_HALT_BIT = 1;
    localparam int CTRL_RESTART_BIT = 2;

    // status register fields
    localparam int ST_DEBUG_BIT = 0;
    localparam int ST_TRACK_BIT = 1;
    localparam int ST_ENABLE_BIT = 2;
    localparam int ST_PEND_BIT = 3;

    // comms status fields
    localparam int CM_RX_FULL_BIT = 0;
    localparam int CM_TX_EMPTY_BIT = 1;

    // interrupt event positions; units 0 and 1 use EV_UNIT0 + n, further units raise no event
    localparam int EV_W = 7;
    localparam int EV_ENTRY = 0;
    localparam int EV_RX = 1;
    localparam int EV_TX = 2;
    localparam int EV_UNIT0 = 3;
    localparam int EV_DWATCH = 5;
    localparam int EV_IBREAK = 6;

    // watch unit control fields
    localparam int UC_W = 4;
    localparam int UC_EN = 0;
    localparam int UC_EXT = 1;
    localparam int UC_WRITE = 2;
    localparam int UC_RW_ANY = 3;

    // reset values
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'hffff_ffff;
    localparam logic [UC_W-1:0] UCTRL_RST = 4'h0;
    localparam logic [EV_W-1:0] EV_RST = 7'h00;

    typedef enum logic {DBG_RUN, DBG_HALTED} dbg_state_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic write;
    } core_bus_s;

    typedef struct packed {
        logic [31:0] aval;
        logic [31:0] amask;
        logic [31:0] dval;
        logic [31:0] dmask;
        logic [UC_W-1:0] ctrl;
    } watch_cfg_s;

    typedef struct packed {
        logic ext_halt;
        logic feat_en;
        logic track;
        logic dwatch;
        logic ibreak;
        logic rx_wr;
        logic tx_rd;
    } pin_in_s;

endpackage

// >>> watch_unit.sv
// Purpose: one watchpoint comparator with registered match and hit
// Assumes: mask bit set means the bit is ignored
// Notes: match ignores the enable bit, hit honours it
`timescale 1ns/1ns
module watch_unit (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // compare inputs
    input wire debug_if_pkg::watch_cfg_s cfg_i,
    input wire debug_if_pkg::core_bus_s bus_i,
    input wire logic cond_i,
    // results
    output logic match_o,
    output logic hit_o
);
    import debug_if_pkg::*;

    logic addr_ok;
    logic data_ok;
    logic rw_ok;
    logic cond_ok;
    logic next_match;

    always_comb begin
        addr_ok = ((bus_i.addr ^ cfg_i.aval) & ~cfg_i.amask) == 32'h0000_0000;
        data_ok = ((bus_i.data ^ cfg_i.dval) & ~cfg_i.dmask) == 32'h0000_0000;
        rw_ok = cfg_i.ctrl[UC_RW_ANY] | (bus_i.write == cfg_i.ctrl[UC_WRITE]);
        cond_ok = ~cfg_i.ctrl[UC_EXT] | cond_i;
        next_match = addr_ok & data_ok & rw_ok & cond_ok;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            match_o <= 1'b0;
            hit_o <= 1'b0;
        end else if (ce_i) begin
            match_o <= next_match;
            hit_o <= next_match & cfg_i.ctrl[UC_EN];
        end
    end
endmodule

// >>> debug_signal_if.sv
// Purpose: debug-side signal logic: halt control, comms flags, watch units, AHB-Lite registers
// Assumes: core-side inputs are on clk_i; pin inputs are asynchronous
// Notes: zero-wait slave, read data is captured in the address phase
`timescale 1ns/1ns
module debug_signal_if #(
    parameter int NUM_UNITS = 2
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // debug pins from the host side
    input wire logic external_halt_request_i,
    input wire logic debug_feature_enable_i,
    input wire logic tracking_mode_i,
    input wire logic [NUM_UNITS-1:0] watch_unit_condition_i,
    input wire logic external_data_watch_i,
    input wire logic external_instr_break_i,
    // host comms port
    input wire logic [31:0] host_rx_data_i,
    input wire logic host_rx_write_i,
    input wire logic host_tx_read_i,
    output logic [31:0] comms_tx_data_o,
    // core side
    input wire debug_if_pkg::core_bus_s core_bus_i,
    input wire logic instr_done_i,
    input wire logic exec_valid_i,
    input wire logic cond_pass_i,
    // status outputs
    output logic comms_rx_full_o,
    output logic comms_tx_empty_o,
    output logic debug_state_ack_o,
    output logic internal_halt_request_o,
    output logic instr_executed_flag_o,
    output logic [NUM_UNITS-1:0] watch_unit_match_o,
    output logic irq_o
);
    import debug_if_pkg::*;

    // pin synchronisers
    pin_in_s pin_meta;
    pin_in_s pin_sync;
    logic [NUM_UNITS-1:0] cond_meta;
    logic [NUM_UNITS-1:0] cond_sync;
    logic [31:0] rx_meta;
    logic [31:0] rx_sync;
    logic rx_wr_q;
    logic tx_rd_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
            cond_meta <= '0;
            cond_sync <= '0;
            rx_meta <= WORD_RST;
            rx_sync <= WORD_RST;
            rx_wr_q <= 1'b0;
            tx_rd_q <= 1'b0;
        end else if (ce_i) begin
            pin_meta <= '{ext_halt: external_halt_request_i, feat_en: debug_feature_enable_i,
                          track: tracking_mode_i, dwatch: external_data_watch_i,
                          ibreak: external_instr_break_i, rx_wr: host_rx_write_i,
                          tx_rd: host_tx_read_i};
            pin_sync <= pin_meta;
            cond_meta <= watch_unit_condition_i;
            cond_sync <= cond_meta;
            rx_meta <= host_rx_data_i;
            rx_sync <= rx_meta;
            rx_wr_q <= pin_sync.rx_wr;
            tx_rd_q <= pin_sync.tx_rd;
        end
    end

    logic host_wr_evt;
    logic host_rd_evt;
    logic feat_en;
    assign host_wr_evt = pin_sync.rx_wr & ~rx_wr_q;
    assign host_rd_evt = pin_sync.tx_rd & ~tx_rd_q;
    assign feat_en = pin_sync.feat_en;

    // ahb-lite address phase
    logic addr_take;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic wr_en;
    logic rd_take;
    logic [7:0] rd_addr;
    assign addr_take = hsel_i & htrans_i[1] & hready_i;
    assign rd_take = addr_take & ~hwrite_i;
    assign rd_addr = haddr_i[7:0];
    assign wr_en = wr_pend & ce_i;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else if (ce_i) begin
            wr_pend <= addr_take & hwrite_i;
            if (addr_take) begin
                wr_addr <= haddr_i[7:0];
            end
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    function automatic logic hit_reg(input logic [7:0] a, input logic [7:0] off);
        hit_reg = (a == off);
    endfunction

    // control and enable registers
    logic ctrl_halt;
    logic [EV_W-1:0] irq_en;
    logic restart;
    assign restart = wr_en & hit_reg(wr_addr, OFF_CTRL) & hwdata_i[CTRL_RESTART_BIT];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_halt <= WORD_RST[CTRL_HALT_BIT];
            irq_en <= EV_RST;
        end else if (ce_i) begin
            if (wr_en & hit_reg(wr_addr, OFF_CTRL)) begin
                ctrl_halt <= hwdata_i[CTRL_HALT_BIT];
            end
            if (wr_en & hit_reg(wr_addr, OFF_IRQ_EN)) begin
                irq_en <= hwdata_i[EV_W-1:0];
            end
        end
    end

    // watch unit configuration and instances
    watch_cfg_s ucfg [NUM_UNITS];
    logic [NUM_UNITS-1:0] unit_hit;

    genvar u;
    generate
        for (u = 0; u < NUM_UNITS; u++) begin : g_unit
            localparam logic [7:0] BASE = 8'(OFF_UNIT_BASE + u * UNIT_STRIDE);
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    ucfg[u] <= '{aval: WORD_RST, amask: MASK_RST, dval: WORD_RST,
                                 dmask: MASK_RST, ctrl: UCTRL_RST};
                end else if (wr_en) begin
                    if (hit_reg(wr_addr, 8'(BASE + OFF_U_AVAL))) begin
                        ucfg[u].aval <= hwdata_i;
                    end
                    if (hit_reg(wr_addr, 8'(BASE + OFF_U_AMASK))) begin
                        ucfg[u].amask <= hwdata_i;
                    end
                    if (hit_reg(wr_addr, 8'(BASE + OFF_U_DVAL))) begin
                        ucfg[u].dval <= hwdata_i;
                    end
                    if (hit_reg(wr_addr, 8'(BASE + OFF_U_DMASK))) begin
                        ucfg[u].dmask <= hwdata_i;
                    end
                    if (hit_reg(wr_addr, 8'(BASE + OFF_U_CTRL))) begin
                        ucfg[u].ctrl <= hwdata_i[UC_W-1:0];
                    end
                end
            end
            watch_unit i_unit (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .cfg_i(ucfg[u]),
                .bus_i(core_bus_i),
                .cond_i(cond_sync[u]),
                .match_o(watch_unit_match_o[u]),
                .hit_o(unit_hit[u])
            );
        end
    endgenerate

    // halt request to the core
    logic halt_req;
    assign halt_req = (pin_sync.ext_halt | ctrl_halt) & feat_en;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            internal_halt_request_o <= 1'b0;
        end else if (ce_i) begin
            internal_halt_request_o <= halt_req;
        end
    end

    // break and watch hits held until the instruction boundary
    logic brk_pend;
    logic new_hit;
    assign new_hit = (|unit_hit) | pin_sync.dwatch | pin_sync.ibreak;

    // debug state machine
    dbg_state_e state;
    logic enter;
    // tracking mode reports hits but does not stop the core
    assign enter = feat_en & instr_done_i & (halt_req | (brk_pend & ~pin_sync.track));

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= DBG_RUN;
            brk_pend <= 1'b0;
        end else if (ce_i) begin
            case (state)
                DBG_RUN: begin
                    if (enter) begin
                        state <= DBG_HALTED;
                        brk_pend <= 1'b0;
                    end else if (feat_en & new_hit & ~pin_sync.track) begin
                        brk_pend <= 1'b1;
                    end else if (~feat_en) begin
                        brk_pend <= 1'b0;
                    end
                end
                DBG_HALTED: begin
                    if (restart | ~feat_en) begin
                        state <= DBG_RUN;
                    end
                end
                default: begin
                    state <= DBG_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            debug_state_ack_o <= 1'b0;
        end else if (ce_i) begin
            debug_state_ack_o <= (state == DBG_HALTED);
        end
    end

    // instruction executed flag
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            instr_executed_flag_o <= 1'b0;
        end else if (ce_i) begin
            instr_executed_flag_o <= exec_valid_i & cond_pass_i;
        end
    end

    // comms channel words and flags
    logic [31:0] rx_word;
    logic rx_read;
    logic tx_write;
    assign rx_read = rd_take & hit_reg(rd_addr, OFF_RX_DATA);
    assign tx_write = wr_en & hit_reg(wr_addr, OFF_TX_DATA);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_word <= WORD_RST;
            comms_rx_full_o <= 1'b0;
            comms_tx_empty_o <= 1'b1;
            comms_tx_data_o <= WORD_RST;
        end else if (ce_i) begin
            if (host_wr_evt) begin
                rx_word <= rx_sync;
                comms_rx_full_o <= 1'b1;
            end else if (rx_read) begin
                comms_rx_full_o <= 1'b0;
            end
            if (tx_write) begin
                comms_tx_data_o <= hwdata_i;
                comms_tx_empty_o <= 1'b0;
            end else if (host_rd_evt) begin
                comms_tx_empty_o <= 1'b1;
            end
        end
    end

    // interrupt status, set wins over clear
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;

    always_comb begin
        ev_set = EV_RST;
        ev_set[EV_ENTRY] = enter & (state == DBG_RUN);
        ev_set[EV_RX] = host_wr_evt;
        ev_set[EV_TX] = host_rd_evt & ~comms_tx_empty_o;
        ev_set[EV_DWATCH] = pin_sync.dwatch & feat_en;
        ev_set[EV_IBREAK] = pin_sync.ibreak & feat_en;
        for (int k = 0; k < 2 && k < NUM_UNITS; k++) begin
            ev_set[EV_UNIT0 + k] = unit_hit[k] & feat_en;
        end
        ev_clr = EV_RST;
        if (wr_en & hit_reg(wr_addr, OFF_IRQ_CLR)) begin
            ev_clr = hwdata_i[EV_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_stat <= EV_RST;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_stat <= (irq_stat & ~ev_clr) | ev_set;
            irq_o <= |(((irq_stat & ~ev_clr) | ev_set) & irq_en);
        end
    end

    // read mux, captured in the address phase
    logic [31:0] rd_word;

    always_comb begin
        rd_word = WORD_RST;
        case (rd_addr)
            OFF_CTRL: rd_word[CTRL_HALT_BIT] = ctrl_halt;
            OFF_STATUS: begin
                rd_word[ST_DEBUG_BIT] = (state == DBG_HALTED);
                rd_word[ST_TRACK_BIT] = pin_sync.track;
                rd_word[ST_ENABLE_BIT] = feat_en;
                rd_word[ST_PEND_BIT] = brk_pend;
            end
            OFF_RX_DATA: rd_word = rx_word;
            OFF_COMMS: begin
                rd_word[CM_RX_FULL_BIT] = comms_rx_full_o;
                rd_word[CM_TX_EMPTY_BIT] = comms_tx_empty_o;
            end
            OFF_IRQ_STAT: rd_word[EV_W-1:0] = irq_stat;
            OFF_IRQ_EN: rd_word[EV_W-1:0] = irq_en;
            default: begin
                for (int k = 0; k < NUM_UNITS; k++) begin
                    if (rd_addr == 8'(OFF_UNIT_BASE + k * UNIT_STRIDE + OFF_U_AVAL)) begin
                        rd_word = ucfg[k].aval;
                    end
                    if (rd_addr == 8'(OFF_UNIT_BASE + k * UNIT_STRIDE + OFF_U_AMASK)) begin
                        rd_word = ucfg[k].amask;
                    end
                    if (rd_addr == 8'(OFF_UNIT_BASE + k * UNIT_STRIDE + OFF_U_DVAL)) begin
                        rd_word = ucfg[k].dval;
                    end
                    if (rd_addr == 8'(OFF_UNIT_BASE + k * UNIT_STRIDE + OFF_U_DMASK)) begin
                        rd_word = ucfg[k].dmask;
                    end
                    if (rd_addr == 8'(OFF_UNIT_BASE + k * UNIT_STRIDE + OFF_U_CTRL)) begin
                        rd_word[UC_W-1:0] = ucfg[k].ctrl;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hrdata_o <= WORD_RST;
        end else if (ce_i) begin
            if (rd_take) begin
                hrdata_o <= rd_word;
            end
        end
    end

endmodule

// >>> debug_if_monitor.sv
// Purpose: port checks of the debug block
// Assumes: single clock domain, ce_i held high
// Notes: bound into debug_signal_if
`timescale 1ns/1ns
module debug_if_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // pins and core side
    input wire logic external_halt_request_i,
    input wire logic debug_feature_enable_i,
    input wire logic host_rx_write_i,
    input wire logic host_tx_read_i,
    input wire logic instr_done_i,
    input wire logic exec_valid_i,
    input wire logic cond_pass_i,
    // status outputs
    input wire logic comms_rx_full_o,
    input wire logic comms_tx_empty_o,
    input wire logic debug_state_ack_o,
    input wire logic internal_halt_request_o,
    input wire logic instr_executed_flag_o
);
    import debug_if_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic exec_ok;
    assign exec_ok = exec_valid_i && cond_pass_i;
    sequence pins_up;
        (external_halt_request_i && debug_feature_enable_i) [*4];
    endsequence
    sequence gate_low;
        (!debug_feature_enable_i) [*5];
    endsequence
    sequence rd_rx;
        hsel_i && htrans_i[1] && hready_i && !hwrite_i && haddr_i[7:0] == OFF_RX_DATA;
    endsequence
    sequence wr_tx;
        hsel_i && htrans_i[1] && hready_i && hwrite_i && haddr_i[7:0] == OFF_TX_DATA ##1 1'b1;
    endsequence
    rx_set_a: assert property ($rose(host_rx_write_i) |-> ##[1:5] comms_rx_full_o)
        else $error("rx full not raised");
    rx_clear_a: assert property (rd_rx |=> !comms_rx_full_o)
        else $error("rx full not cleared by read");
    tx_fill_a: assert property (wr_tx |=> !comms_tx_empty_o)
        else $error("tx empty after core write");
    tx_take_a: assert property ($rose(host_tx_read_i) |-> ##[1:5] comms_tx_empty_o)
        else $error("tx empty not raised");
    ack_drop_a: assert property ($fell(debug_state_ack_o) |-> $past(hwdata_i[2]) || $past(hwdata_i[2], 2)
        || !$past(debug_feature_enable_i, 3) || !$past(debug_feature_enable_i, 4))
        else $error("ack dropped without cause");
    gate_off_a: assert property (gate_low |-> !internal_halt_request_o && !debug_state_ack_o)
        else $error("debug active while disabled");
    halt_follow_a: assert property (pins_up |-> internal_halt_request_o)
        else $error("halt request not forwarded");
    ack_entry_a: assert property ($rose(debug_state_ack_o) |-> $past(instr_done_i) || $past(instr_done_i, 2))
        else $error("debug entry mid instruction");
    exec_hi_a: assert property (exec_ok |=> instr_executed_flag_o)
        else $error("executed flag missing");
    exec_lo_a: assert property (!exec_ok |=> !instr_executed_flag_o)
        else $error("executed flag spurious");
    bus_okay_a: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or not okay");
endmodule
bind debug_signal_if debug_if_monitor mon (.*);

// >>> debug_host.sv
// Purpose: external debug host model
// Assumes: pins change right after a rising edge
// Notes: rx word scrambled after its hold
`timescale 1ns/1ns
module debug_host (
    // clock
    input wire logic clk_i,
    // pins toward the block
    output debug_if_pkg::pin_in_s pins_o,
    output logic [1:0] cond_o,
    output logic [31:0] rx_data_o
);
    import debug_if_pkg::*;
    initial begin
        pins_o = '0;
        pins_o.feat_en = 1'b1;
        cond_o = 2'b00;
        rx_data_o = 32'h0;
    end
    task automatic levels(input logic halt, input logic en, input logic track, input logic [1:0] cond);
        @(posedge clk_i);
        pins_o.ext_halt <= halt;
        pins_o.feat_en <= en;
        pins_o.track <= track;
        cond_o <= cond;
    endtask
    task automatic strike(input logic dw, input logic ib);
        @(posedge clk_i);
        pins_o.dwatch <= dw;
        pins_o.ibreak <= ib;
        @(posedge clk_i);
        pins_o.dwatch <= 1'b0;
        pins_o.ibreak <= 1'b0;
    endtask
    task automatic send_rx(input logic [31:0] w);
        @(posedge clk_i);
        rx_data_o <= w;
        pins_o.rx_wr <= 1'b1;
        repeat (5) @(posedge clk_i);
        pins_o.rx_wr <= 1'b0;
        rx_data_o <= ~w;
    endtask
    task automatic take_tx();
        @(posedge clk_i);
        pins_o.tx_rd <= 1'b1;
        repeat (3) @(posedge clk_i);
        pins_o.tx_rd <= 1'b0;
    endtask
endmodule

// >>> tb.sv
// Purpose: bench for the debug block
// Assumes: outputs read at an edge hold pre-edge values
// Notes: pins from debug_host
`timescale 1ns/1ns
module tb;
    import debug_if_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic instr_done_i = 1'b0;
    logic exec_valid_i = 1'b0;
    logic cond_pass_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [1:0] htrans_i = 2'b00;
    core_bus_s core_bus_i = '0;
    logic [31:0] hrdata_o, comms_tx_data_o, rx_word;
    logic [1:0] watch_unit_match_o, cond;
    logic hreadyout_o, hresp_o, comms_rx_full_o, comms_tx_empty_o, debug_state_ack_o;
    logic internal_halt_request_o, instr_executed_flag_o, irq_o;
    pin_in_s pins;
    int fail_count = 0;
    int compares = 0;
    debug_host host (.clk_i, .pins_o(pins), .cond_o(cond), .rx_data_o(rx_word));
    debug_signal_if dut (.clk_i, .sys_rst_i, .ce_i(1'b1), .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
        .external_halt_request_i(pins.ext_halt), .debug_feature_enable_i(pins.feat_en),
        .tracking_mode_i(pins.track), .watch_unit_condition_i(cond), .external_data_watch_i(pins.dwatch),
        .external_instr_break_i(pins.ibreak), .host_rx_data_i(rx_word), .host_rx_write_i(pins.rx_wr),
        .host_tx_read_i(pins.tx_rd), .comms_tx_data_o, .core_bus_i, .instr_done_i, .exec_valid_i,
        .cond_pass_i, .comms_rx_full_o, .comms_tx_empty_o, .debug_state_ack_o, .internal_halt_request_o,
        .instr_executed_flag_o, .watch_unit_match_o, .irq_o);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel_i <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i <= {24'h0, a};
        hwrite_i <= wr;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, exp);
    endtask
    task automatic done_pulse();
        instr_done_i <= 1'b1;
        @(posedge clk_i);
        instr_done_i <= 1'b0;
    endtask
    task automatic close_out();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        close_out();
    end
    initial begin
        idle(10);
        sys_rst_i <= 1'b0;
        idle(2);
        chk({27'h0, hreadyout_o, hresp_o, comms_tx_empty_o, comms_rx_full_o, debug_state_ack_o}, 32'h14);
        rd(OFF_STATUS, 32'h4);
        rd(8'h3c, 32'h0);
        rd(OFF_UNIT_BASE + OFF_U_AMASK, 32'hffff_ffff);
        wr(OFF_IRQ_EN, 32'h1);
        wr(OFF_CTRL, 32'h2);
        idle(3);
        chk({31'h0, internal_halt_request_o}, 32'h1);
        rd(OFF_CTRL, 32'h2);
        idle(5);
        chk({31'h0, debug_state_ack_o}, 32'h0);
        done_pulse();
        idle(2);
        chk({30'h0, debug_state_ack_o, irq_o}, 32'h3);
        rd(OFF_STATUS, 32'h5);
        wr(OFF_IRQ_EN, 32'h0);
        idle(2);
        chk({31'h0, irq_o}, 32'h0);
        wr(OFF_IRQ_CLR, 32'h1);
        rd(OFF_IRQ_STAT, 32'h0);
        wr(OFF_CTRL, 32'h4);
        idle(3);
        chk({30'h0, debug_state_ack_o, internal_halt_request_o}, 32'h0);
        host.levels(1'b1, 1'b1, 1'b0, 2'b00);
        idle(4);
        chk({31'h0, internal_halt_request_o}, 32'h1);
        host.levels(1'b1, 1'b0, 1'b0, 2'b00);
        idle(4);
        done_pulse();
        idle(2);
        chk({30'h0, debug_state_ack_o, internal_halt_request_o}, 32'h0);
        host.levels(1'b0, 1'b1, 1'b1, 2'b00);
        idle(4);
        rd(OFF_STATUS, 32'h6);
        host.strike(1'b1, 1'b0);
        host.strike(1'b0, 1'b1);
        idle(4);
        done_pulse();
        idle(2);
        chk({31'h0, debug_state_ack_o}, 32'h0);
        rd(OFF_IRQ_STAT, 32'h60);
        wr(OFF_IRQ_CLR, 32'h7f);
        host.levels(1'b0, 1'b1, 1'b0, 2'b00);
        idle(4);
        host.strike(1'b1, 1'b0);
        idle(4);
        rd(OFF_STATUS, 32'hc);
        done_pulse();
        idle(2);
        chk({31'h0, debug_state_ack_o}, 32'h1);
        wr(OFF_CTRL, 32'h4);
        idle(3);
        host.send_rx(32'hc0de_0001);
        chk({31'h0, comms_rx_full_o}, 32'h1);
        rd(OFF_COMMS, 32'h3);
        rd(OFF_RX_DATA, 32'hc0de_0001);
        chk({31'h0, comms_rx_full_o}, 32'h0);
        wr(OFF_TX_DATA, 32'h5a5a_0002);
        idle(1);
        chk({31'h0, comms_tx_empty_o}, 32'h0);
        chk(comms_tx_data_o, 32'h5a5a_0002);
        host.take_tx();
        idle(4);
        chk({31'h0, comms_tx_empty_o}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            exec_valid_i <= i[0];
            cond_pass_i <= i[1];
            idle(2);
            chk({31'h0, instr_executed_flag_o}, {31'h0, i == 3});
        end
        wr(OFF_UNIT_BASE + OFF_U_AVAL, 32'h1000);
        wr(OFF_UNIT_BASE + OFF_U_AMASK, 32'h0);
        wr(OFF_UNIT_BASE + OFF_U_CTRL, 32'h8);
        wr(OFF_UNIT_BASE + UNIT_STRIDE + OFF_U_CTRL, 32'ha);
        core_bus_i <= '{addr: 32'h1000, data: 32'h0, write: 1'b1};
        idle(2);
        chk({30'h0, watch_unit_match_o}, 32'h1);
        core_bus_i <= '{addr: 32'h1004, data: 32'h0, write: 1'b1};
        host.levels(1'b0, 1'b1, 1'b0, 2'b10);
        idle(4);
        chk({30'h0, watch_unit_match_o}, 32'h2);
        close_out();
    end
endmodule
